// ===== logic/event_select_pkg.sv
/*
 * Shared constants for the event source select front end: register offsets,
 * field positions, reset values, clock select codes and bus state codes.
 * Assumes a 250 MHz system clock and an AXI4-Lite register bus.
 */
package event_select_pkg;

   // bus geometry
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int SRC_N  = 16;

   // register byte offsets
   localparam logic [7:0] OFS_CONTROL        = 8'h00;
   localparam logic [7:0] OFS_RISE_EN_LOW    = 8'h04;
   localparam logic [7:0] OFS_RISE_EN_HIGH   = 8'h08;
   localparam logic [7:0] OFS_FALL_EN_LOW    = 8'h0C;
   localparam logic [7:0] OFS_FALL_EN_HIGH   = 8'h10;
   localparam logic [7:0] OFS_RISE_MODE_LOW  = 8'h14;
   localparam logic [7:0] OFS_RISE_MODE_HIGH = 8'h18;
   localparam logic [7:0] OFS_FALL_MODE_LOW  = 8'h1C;
   localparam logic [7:0] OFS_FALL_MODE_HIGH = 8'h20;
   localparam logic [7:0] OFS_RISE_DELAY     = 8'h24;
   localparam logic [7:0] OFS_FALL_DELAY     = 8'h28;
   localparam logic [7:0] OFS_STATUS         = 8'h2C;

   // control field positions and reset values
   localparam int         CTRL_SEL_LSB    = 0;
   localparam int         CTRL_ENABLE_BIT = 7;
   localparam logic [7:0] RESET_BYTE      = 8'h00;

   // source bit positions
   localparam int SRC_INPUT_PIN      = 0;
   localparam int SRC_COMPARATOR_ONE = 1;

   // reference clock select codes
   localparam logic [1:0] SEL_FAST     = 2'h0;
   localparam logic [1:0] SEL_INSTR    = 2'h1;
   localparam logic [1:0] SEL_SYS      = 2'h2;
   localparam logic [1:0] SEL_RESERVED = 2'h3;

   // clock rates and dividers
   localparam int         SYS_CLK_MHZ  = 250;
   localparam int         FAST_OSC_MHZ = 16;
   localparam logic [1:0] INSTR_LAST   = 2'h3;

   // bus responses
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // bus channel states
   typedef enum logic [1:0] {
      CH_IDLE = 2'b01,
      CH_RESP = 2'b10
   } chan_state_e;

endpackage

// ===== logic/clock_tick_divider.sv
/*
 * Reference clock tick generator: one-cycle enables at the fast oscillator
 * rate, the instruction rate and the system rate, one of them selected.
 * Assumes the select code is a stable register value.
 */
`timescale 1ns/100ps
module clock_tick_divider (
   // system
   input  logic       clk,
   input  logic       rst_n,
   // control
   input  logic       sleep,
   input  logic [1:0] sel,
   // tick out
   output logic       tick
);
   logic [7:0] fast_acc;
   logic [8:0] fast_sum;
   logic       fast_tick;
   logic [1:0] instr_cnt;
   logic       instr_tick;

   // fractional accumulator, averages the oscillator rate exactly
   assign fast_sum  = {1'b0, fast_acc} + 9'(event_select_pkg::FAST_OSC_MHZ);
   assign fast_tick = fast_sum >= 9'(event_select_pkg::SYS_CLK_MHZ);
   assign instr_tick = instr_cnt == event_select_pkg::INSTR_LAST && !sleep;

   // oscillator keeps running in sleep
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         fast_acc <= 8'h00;
      end else if (fast_tick) begin
         fast_acc <= 8'(fast_sum - 9'(event_select_pkg::SYS_CLK_MHZ));
      end else begin
         fast_acc <= fast_sum[7:0];
      end
   end

   // divide by four, halted in sleep
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         instr_cnt <= 2'h0;
      end else if (!sleep) begin
         instr_cnt <= instr_cnt + 2'h1;
      end
   end

   // select the reference, fourth code gives no ticks
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         tick <= 1'b0;
      end else begin
         case (sel)
            event_select_pkg::SEL_FAST:  tick <= fast_tick;
            event_select_pkg::SEL_INSTR: tick <= instr_tick;
            event_select_pkg::SEL_SYS:   tick <= !sleep;
            default:                     tick <= 1'b0;
         endcase
      end
   end

   fast_gap_a: assert property (@(posedge clk) disable iff (!rst_n)
      fast_tick |=> !fast_tick [*8]) else $error("fast tick too frequent");
   instr_gap_a: assert property (@(posedge clk) disable iff (!rst_n)
      instr_tick |=> !instr_tick [*3]) else $error("instruction tick too frequent");
endmodule

// ===== logic/event_detect.sv
/*
 * Per-source edge or level detection, gated by enables, ORed into one
 * level hit and one edge hit. Assumes sources are synchronous to clk.
 */
`timescale 1ns/100ps
module event_detect #(
   parameter int N = 16
) (
   // system
   input  logic         clk,
   input  logic         rst_n,
   // configuration and sources
   input  logic [N-1:0] src,
   input  logic [N-1:0] en,
   input  logic [N-1:0] mode,
   // detected hits
   output logic         level_hit,
   output logic         edge_hit
);
   logic [N-1:0] prev;

   // previous sample for transition detect
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         prev <= '0;
      end else begin
         prev <= src;
      end
   end

   // mode one is edge, mode zero is level, disabled sources drop out
   assign level_hit = |(en & ~mode & src);
   assign edge_hit  = |(en & mode & src & ~prev);
endmodule

// ===== logic/waveform_event_select.sv
/*
 * Event source select front end of a complementary waveform generator:
 * AXI4-Lite register file, reference clock tick, rising and falling
 * source detection, phase delay and drive state.
 * Assumes sources and sleep are synchronous to clk.
 */
`timescale 1ns/100ps
// Function
// - timers tick on selected reference clock
// - two-bit select picks oscillator, instruction, system
// - per-source enable bits, rising and falling
// - enabled sources ORed into one event
// - per-source mode bits in mode registers
// - mode one edge, mode zero level
// - asserted rising level holds drive on
// - edge events only on real transitions
// - comparator edge gives delayed rising event
// - comparator level gives immediate rising event
// - disabled comparator ignored for rising
// - pin edge gives delayed rising event
// - pin level gives immediate rising event
// - disabled pin ignored for rising
module waveform_event_select #(
   parameter int DELAY_W = 8
) (
   // system
   input  logic        clk,
   input  logic        rst_n,
   // write address
   input  logic        awvalid,
   output logic        awready,
   input  logic [7:0]  awaddr,
   // write data
   input  logic        wvalid,
   output logic        wready,
   input  logic [31:0] wdata,
   input  logic [3:0]  wstrb,
   // write response
   output logic        bvalid,
   input  logic        bready,
   output logic [1:0]  bresp,
   // read address
   input  logic        arvalid,
   output logic        arready,
   input  logic [7:0]  araddr,
   // read data
   output logic        rvalid,
   input  logic        rready,
   output logic [31:0] rdata,
   output logic [1:0]  rresp,
   // event sources and power state
   input  logic [15:0] event_sources,
   input  logic        sleep,
   // generator side
   output logic        waveform_timer_clock,
   output logic        rise_event,
   output logic        fall_event,
   output logic        drive_on
);
   // configuration
   logic [7:0]         control;
   logic [15:0]        rise_en;
   logic [15:0]        fall_en;
   logic [15:0]        rise_mode;
   logic [15:0]        fall_mode;
   logic [DELAY_W-1:0] rise_delay;
   logic [DELAY_W-1:0] fall_delay;
   logic               gen_enable;
   logic [1:0]         clk_sel;
   // bus channels
   event_select_pkg::chan_state_e wr_state;
   event_select_pkg::chan_state_e rd_state;
   logic               aw_held;
   logic               w_held;
   logic [7:0]         wr_addr;
   logic [31:0]        wr_data;
   logic [3:0]         wr_strb;
   logic               wr_do;
   logic [31:0]        rd_word;
   // events
   logic               tick;
   logic               rise_level;
   logic               rise_edge;
   logic               fall_level;
   logic               fall_edge;
   logic               rise_pend;
   logic               fall_pend;
   logic [DELAY_W-1:0] rise_cnt;
   logic [DELAY_W-1:0] fall_cnt;
   logic               rise_fire;
   logic               fall_fire;

   // offsets are contiguous words up to the status register
   function automatic logic addr_known(input logic [7:0] a);
      return a[7:2] <= event_select_pkg::OFS_STATUS[7:2];
   endfunction

   // control fields
   assign gen_enable = control[event_select_pkg::CTRL_ENABLE_BIT];
   assign clk_sel    = control[event_select_pkg::CTRL_SEL_LSB +: 2];

   // write channel: address and data taken in either order
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         wr_state <= event_select_pkg::CH_IDLE;
         awready  <= 1'b0;
         wready   <= 1'b0;
         aw_held  <= 1'b0;
         w_held   <= 1'b0;
         wr_addr  <= 8'h00;
         wr_data  <= 32'h0000_0000;
         wr_strb  <= 4'h0;
         bvalid   <= 1'b0;
         bresp    <= event_select_pkg::RESP_OKAY;
      end else begin
         case (wr_state)
            event_select_pkg::CH_IDLE: begin
               if (awvalid && awready) begin
                  aw_held <= 1'b1;
                  wr_addr <= awaddr;
                  awready <= 1'b0;
               end else if (!aw_held) begin
                  awready <= 1'b1;
               end
               if (wvalid && wready) begin
                  w_held  <= 1'b1;
                  wr_data <= wdata;
                  wr_strb <= wstrb;
                  wready  <= 1'b0;
               end else if (!w_held) begin
                  wready <= 1'b1;
               end
               if (wr_do) begin
                  aw_held  <= 1'b0;
                  w_held   <= 1'b0;
                  bvalid   <= 1'b1;
                  bresp    <= addr_known(wr_addr) ? event_select_pkg::RESP_OKAY
                                                  : event_select_pkg::RESP_SLVERR;
                  wr_state <= event_select_pkg::CH_RESP;
               end
            end
            event_select_pkg::CH_RESP: begin
               if (bready) begin
                  bvalid   <= 1'b0;
                  wr_state <= event_select_pkg::CH_IDLE;
               end
            end
            default: wr_state <= event_select_pkg::CH_IDLE;
         endcase
      end
   end

   // register update once both halves of a write are held
   assign wr_do = wr_state == event_select_pkg::CH_IDLE && aw_held && w_held;

   // configuration registers, byte lane zero only
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         control    <= event_select_pkg::RESET_BYTE;
         rise_en    <= {2{event_select_pkg::RESET_BYTE}};
         fall_en    <= {2{event_select_pkg::RESET_BYTE}};
         rise_mode  <= {2{event_select_pkg::RESET_BYTE}};
         fall_mode  <= {2{event_select_pkg::RESET_BYTE}};
         rise_delay <= '0;
         fall_delay <= '0;
      end else if (wr_do && wr_strb[0]) begin
         case ({wr_addr[7:2], 2'b00})
            event_select_pkg::OFS_CONTROL:        control         <= wr_data[7:0];
            event_select_pkg::OFS_RISE_EN_LOW:    rise_en[7:0]    <= wr_data[7:0];
            event_select_pkg::OFS_RISE_EN_HIGH:   rise_en[15:8]   <= wr_data[7:0];
            event_select_pkg::OFS_FALL_EN_LOW:    fall_en[7:0]    <= wr_data[7:0];
            event_select_pkg::OFS_FALL_EN_HIGH:   fall_en[15:8]   <= wr_data[7:0];
            event_select_pkg::OFS_RISE_MODE_LOW:  rise_mode[7:0]  <= wr_data[7:0];
            event_select_pkg::OFS_RISE_MODE_HIGH: rise_mode[15:8] <= wr_data[7:0];
            event_select_pkg::OFS_FALL_MODE_LOW:  fall_mode[7:0]  <= wr_data[7:0];
            event_select_pkg::OFS_FALL_MODE_HIGH: fall_mode[15:8] <= wr_data[7:0];
            event_select_pkg::OFS_RISE_DELAY:     rise_delay <= wr_data[DELAY_W-1:0];
            event_select_pkg::OFS_FALL_DELAY:     fall_delay <= wr_data[DELAY_W-1:0];
            default: ;
         endcase
      end
   end

   // read word mux, status shows live generator state
   always_comb begin
      rd_word = 32'h0000_0000;
      case ({araddr[7:2], 2'b00})
         event_select_pkg::OFS_CONTROL:        rd_word[7:0] = control;
         event_select_pkg::OFS_RISE_EN_LOW:    rd_word[7:0] = rise_en[7:0];
         event_select_pkg::OFS_RISE_EN_HIGH:   rd_word[7:0] = rise_en[15:8];
         event_select_pkg::OFS_FALL_EN_LOW:    rd_word[7:0] = fall_en[7:0];
         event_select_pkg::OFS_FALL_EN_HIGH:   rd_word[7:0] = fall_en[15:8];
         event_select_pkg::OFS_RISE_MODE_LOW:  rd_word[7:0] = rise_mode[7:0];
         event_select_pkg::OFS_RISE_MODE_HIGH: rd_word[7:0] = rise_mode[15:8];
         event_select_pkg::OFS_FALL_MODE_LOW:  rd_word[7:0] = fall_mode[7:0];
         event_select_pkg::OFS_FALL_MODE_HIGH: rd_word[7:0] = fall_mode[15:8];
         event_select_pkg::OFS_RISE_DELAY:     rd_word[DELAY_W-1:0] = rise_delay;
         event_select_pkg::OFS_FALL_DELAY:     rd_word[DELAY_W-1:0] = fall_delay;
         event_select_pkg::OFS_STATUS:
            rd_word[4:0] = {fall_pend, rise_pend, fall_event, rise_event, drive_on};
         default: rd_word = 32'h0000_0000;
      endcase
   end

   // read channel: one cycle from address to data
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rd_state <= event_select_pkg::CH_IDLE;
         arready  <= 1'b0;
         rvalid   <= 1'b0;
         rdata    <= 32'h0000_0000;
         rresp    <= event_select_pkg::RESP_OKAY;
      end else begin
         case (rd_state)
            event_select_pkg::CH_IDLE: begin
               if (arvalid && arready) begin
                  arready  <= 1'b0;
                  rvalid   <= 1'b1;
                  rdata    <= rd_word;
                  rresp    <= addr_known(araddr) ? event_select_pkg::RESP_OKAY
                                                 : event_select_pkg::RESP_SLVERR;
                  rd_state <= event_select_pkg::CH_RESP;
               end else begin
                  arready <= 1'b1;
               end
            end
            event_select_pkg::CH_RESP: begin
               if (rready) begin
                  rvalid   <= 1'b0;
                  rd_state <= event_select_pkg::CH_IDLE;
               end
            end
            default: rd_state <= event_select_pkg::CH_IDLE;
         endcase
      end
   end

   // reference clock tick
   clock_tick_divider u_tick (
      .clk   (clk),
      .rst_n (rst_n),
      .sleep (sleep),
      .sel   (clk_sel),
      .tick  (tick)
   );

   // rising source detection
   event_detect #(.N(event_select_pkg::SRC_N)) u_rise (
      .clk       (clk),
      .rst_n     (rst_n),
      .src       (event_sources),
      .en        (rise_en),
      .mode      (rise_mode),
      .level_hit (rise_level),
      .edge_hit  (rise_edge)
   );

   // falling source detection
   event_detect #(.N(event_select_pkg::SRC_N)) u_fall (
      .clk       (clk),
      .rst_n     (rst_n),
      .src       (event_sources),
      .en        (fall_en),
      .mode      (fall_mode),
      .level_hit (fall_level),
      .edge_hit  (fall_edge)
   );

   // rising phase delay, counted on reference ticks; a new edge restarts it
   always_ff @(posedge clk) begin
      if (!rst_n || !gen_enable) begin
         rise_pend <= 1'b0;
         rise_cnt  <= '0;
      end else if (rise_edge) begin
         rise_pend <= 1'b1;
         rise_cnt  <= rise_delay;
      end else if (rise_fire) begin
         rise_pend <= 1'b0;
      end else if (rise_pend && tick) begin
         rise_cnt <= rise_cnt - 1'b1;
      end
   end

   // falling phase delay, same scheme
   always_ff @(posedge clk) begin
      if (!rst_n || !gen_enable) begin
         fall_pend <= 1'b0;
         fall_cnt  <= '0;
      end else if (fall_edge) begin
         fall_pend <= 1'b1;
         fall_cnt  <= fall_delay;
      end else if (fall_fire) begin
         fall_pend <= 1'b0;
      end else if (fall_pend && tick) begin
         fall_cnt <= fall_cnt - 1'b1;
      end
   end

   // delay expiry
   assign rise_fire = rise_pend && rise_cnt == '0;
   assign fall_fire = fall_pend && fall_cnt == '0;

   // event outputs: levels immediate, edges after the delay
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rise_event           <= 1'b0;
         fall_event           <= 1'b0;
         waveform_timer_clock <= 1'b0;
      end else begin
         rise_event           <= gen_enable && (rise_level || rise_fire);
         fall_event           <= gen_enable && (fall_level || fall_fire);
         waveform_timer_clock <= tick;
      end
   end

   // drive state: a rising level holds it on over any falling event
   always_ff @(posedge clk) begin
      if (!rst_n || !gen_enable) begin
         drive_on <= 1'b0;
      end else if (rise_level) begin
         drive_on <= 1'b1;
      end else if (fall_level || fall_fire) begin
         drive_on <= 1'b0;
      end else if (rise_fire) begin
         drive_on <= 1'b1;
      end
   end

   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);

   // checks
   sys_tick_a: assert property (
      (clk_sel == event_select_pkg::SEL_SYS && !sleep) [*2] |=> waveform_timer_clock)
      else $error("system select gives no tick");
   reserved_sel_a: assert property (
      (clk_sel == event_select_pkg::SEL_RESERVED) [*2] |=> !waveform_timer_clock)
      else $error("reserved select ticks");
   en_write_a: assert property (
      wr_do && wr_strb[0] && wr_addr == event_select_pkg::OFS_RISE_EN_LOW
      |=> rise_en[7:0] == $past(wr_data[7:0]))
      else $error("rising enable write lost");
   mode_write_a: assert property (
      wr_do && wr_strb[0] && wr_addr == event_select_pkg::OFS_FALL_MODE_HIGH
      |=> fall_mode[15:8] == $past(wr_data[7:0]))
      else $error("falling mode write lost");
   level_rise_a: assert property (
      gen_enable && rise_level |=> rise_event)
      else $error("level source gave no rising event");
   ignored_source_a: assert property (
      (rise_en & event_sources) == 16'h0000 && !rise_pend |=> !rise_event)
      else $error("disabled source gave rising event");
   level_hold_a: assert property (
      gen_enable && rise_level && (fall_level || fall_fire) |=> drive_on)
      else $error("rising level failed to hold drive");
   edge_delay_a: assert property (
      rise_edge && rise_delay == '0 && gen_enable ##1 gen_enable |=> rise_event)
      else $error("edge event not raised after delay");
   stuck_on_a: assert property (
      drive_on && gen_enable && !fall_level && !fall_fire |=> drive_on)
      else $error("drive dropped without falling event");

   // scenarios
   edge_fire_c: cover property (rise_pend && rise_cnt != '0 ##[1:40] rise_event);
   on_off_c: cover property (drive_on ##[1:20] !drive_on);
   slverr_c: cover property (rvalid && rresp == event_select_pkg::RESP_SLVERR);
   fast_sel_c: cover property (clk_sel == event_select_pkg::SEL_FAST && waveform_timer_clock);
endmodule

// ===== testbench/event_source_model.sv
/*
 * Far-side model of the event sources: comparators, timer outputs and
 * the selected input pin. Assumes the bench states the wanted levels.
 */
`timescale 1ns/100ps
module event_source_model (
   // system
   input  wire logic        clk,
   // wanted levels and answer speed
   input  wire logic [15:0] want,
   input  wire logic        slow,
   // source lines
   output logic      [15:0] event_sources
);
   logic [15:0] stage;

   // sources move on the clock; slow adds one stage of lag
   always_ff @(posedge clk) begin
      stage <= want;
      event_sources <= slow ? stage : want;
   end
endmodule

// ===== testbench/tb_top.sv
/*
 * Bench for the event select front end: AXI4-Lite register tasks,
 * clock select counts and event detection scenarios.
 * Assumes a 250 MHz clock and sources from the far-side model.
 */
`timescale 1ns/100ps
module tb_top;
   logic clk, rst_n, awvalid, wvalid, bready, arvalid, rready, sleep, slow;
   logic awready, wready, bvalid, arready, rvalid, tck, rise_event, fall_event, drive_on;
   logic [7:0]  awaddr, araddr;
   logic [31:0] wdata, rdata, d;
   logic [3:0]  wstrb;
   logic [1:0]  bresp, rresp, r;
   logic [15:0] want, event_sources;
   int mismatches, check_count, cyc, t, rs, fl, l0, l3;
   int exp_t[7] = '{32, 125, 500, 0, 0, 32, 0};
   logic [7:0] ctl[7] = '{8'h80, 8'h81, 8'h82, 8'h83, 8'h81, 8'h80, 8'h82};

   waveform_event_select waveform_event_select_inst (.clk(clk), .rst_n(rst_n),
      .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .wvalid(wvalid),
      .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready),
      .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
      .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
      .event_sources(event_sources), .sleep(sleep), .waveform_timer_clock(tck),
      .rise_event(rise_event), .fall_event(fall_event), .drive_on(drive_on));
   event_source_model event_source_model_inst (.clk(clk), .want(want), .slow(slow),
      .event_sources(event_sources));

   // clock and hang guard
   initial begin
      clk = 0;
      forever #2 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         mismatches++;
         finish_test();
      end
   end

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      check_count++;
      if (g !== e) begin
         mismatches++;
         $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask

   // write: address and data offered together, each released when taken
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      logic [1:0] tk;
      tk = 0;
      @(posedge clk);
      awvalid <= 1; wvalid <= 1; awaddr <= a; wdata <= {24'h0, v}; bready <= 1;
      do begin
         @(posedge clk);
         if (awready === 1) begin tk[0] = 1; awvalid <= 0; end
         if (wready === 1) begin tk[1] = 1; wvalid <= 0; end
      end while (tk != 2'h3);
      do @(posedge clk); while (bvalid !== 1);
      r = bresp; bready <= 0;
   endtask

   task automatic rd(input logic [7:0] a);
      @(posedge clk);
      arvalid <= 1; araddr <= a; rready <= 1;
      do @(posedge clk); while (arready !== 1);
      arvalid <= 0;
      do @(posedge clk); while (rvalid !== 1);
      d = rdata; r = rresp; rready <= 0;
   endtask

   // pulse counts over a window, after the configuration settles
   task automatic cnt(input int c);
      t = 0; rs = 0; fl = 0;
      repeat (1) @(posedge clk);
      repeat (c) begin
         @(posedge clk);
         t += (tck === 1); rs += (rise_event === 1); fl += (fall_event === 1);
      end
   endtask

   // cycles from a pin rise to the rising event
   task automatic lat(output int n);
      want[0] <= 0;
      repeat (20) @(posedge clk);
      n = 0;
      want[0] <= 1;
      do begin @(posedge clk); n++; end while (rise_event !== 1 && n < 100);
   endtask

   task automatic finish_test();
      $display("checks=%0d mismatches=%0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask

   initial begin
      {awvalid, wvalid, bready, arvalid, rready, sleep, slow} = 0;
      awaddr = 0; araddr = 0; wdata = 0; wstrb = 4'hF; want = 0;
      mismatches = 0; check_count = 0; cyc = 0; rst_n = 0;
      repeat (12) @(posedge clk);
      rst_n <= 1;
      // reset values, read-write, unmapped and read-only places
      rd(event_select_pkg::OFS_RISE_MODE_LOW); chk(d, 0);
      wr(event_select_pkg::OFS_RISE_MODE_LOW, 8'hA5);
      rd(event_select_pkg::OFS_RISE_MODE_LOW); chk(d, 32'hA5);
      rd(8'h30); chk(d, 0); chk(r, event_select_pkg::RESP_SLVERR);
      wr(8'h30, 8'h5A); chk(r, event_select_pkg::RESP_SLVERR);
      wr(event_select_pkg::OFS_STATUS, 8'hFF); chk(r, event_select_pkg::RESP_OKAY);
      rd(event_select_pkg::OFS_STATUS); chk(d, 0);
      $display("test registers done");
      // tick counts for every select code awake, and all but the reserved code asleep
      for (int i = 0; i < 7; i++) begin
         sleep <= (i > 3);
         wr(event_select_pkg::OFS_CONTROL, ctl[i]);
         cnt(500); chk(t, exp_t[i]);
      end
      sleep <= 0;
      $display("test clock select done");
      // comparator edge: one delayed event, none while held high
      wr(event_select_pkg::OFS_RISE_EN_LOW, 8'h02);
      wr(event_select_pkg::OFS_RISE_MODE_LOW, 8'h02);
      wr(event_select_pkg::OFS_FALL_EN_LOW, 8'h04);
      wr(event_select_pkg::OFS_FALL_MODE_LOW, 8'h04);
      want[1] <= 1;
      cnt(20); chk(rs, 1); chk(drive_on, 1);
      cnt(40); chk(rs, 0); chk(drive_on, 1);
      want[2] <= 1;
      cnt(20); chk(fl, 1); chk(drive_on, 0);
      want[2] <= 0;
      // comparator level: event every cycle, holds drive against falls
      wr(event_select_pkg::OFS_RISE_MODE_LOW, 8'h00);
      cnt(20); chk(rs, 20); chk(drive_on, 1);
      want[2] <= 1;
      cnt(20); chk(fl, 1); chk(drive_on, 1);
      want[2] <= 0;
      // disabled sources ignored in either mode
      want[0] <= 1;
      wr(event_select_pkg::OFS_RISE_EN_LOW, 8'h00);
      cnt(20); chk(rs, 0);
      wr(event_select_pkg::OFS_RISE_MODE_LOW, 8'h03);
      cnt(20); chk(rs, 0);
      $display("test comparator done");
      // pin level, then pin edge with phase delay 0 and 3, slow sources
      wr(event_select_pkg::OFS_RISE_EN_LOW, 8'h01);
      wr(event_select_pkg::OFS_RISE_MODE_LOW, 8'h00);
      cnt(20); chk(rs, 20);
      wr(event_select_pkg::OFS_RISE_MODE_LOW, 8'h01);
      slow <= 1;
      lat(l0); chk(l0, 5);
      wr(event_select_pkg::OFS_RISE_DELAY, 8'h03);
      lat(l3); chk(l3 - l0, 3);
      slow <= 0;
      $display("test input pin done");
      // falling level source in the high byte ORed in
      wr(event_select_pkg::OFS_RISE_EN_LOW, 8'h00);
      want[9] <= 1;
      wr(event_select_pkg::OFS_FALL_EN_HIGH, 8'h02);
      cnt(20); chk(fl, 20); chk(drive_on, 0);
      $display("test falling sources done");
      finish_test();
   end
endmodule
